// File: shared/adc_ctrl_pkg.sv
// Package with the constants and types of the control-byte sequencer.
package adc_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned READY_TIME_NS   = 2000;
  localparam int unsigned READY_CYCLES    =
    (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CTRL_BITS       = 8;
  localparam int unsigned CONV_SCLK_FALLS = 12;

  localparam int unsigned BIT_START       = 7;
  localparam int unsigned BIT_CHAN_HI     = 6;
  localparam int unsigned BIT_CHAN_LO     = 4;
  localparam int unsigned BIT_POLARITY    = 3;
  localparam int unsigned BIT_INPUT_CFG   = 2;
  localparam int unsigned BIT_POWER_HI    = 1;
  localparam int unsigned BIT_POWER_LO    = 0;

  localparam logic [7:0]  CTRL_WORD_RESET = 8'h00;

  typedef enum logic [1:0] {
    FULL_SLEEP_MODE  = 2'b00,
    QUICK_SLEEP_MODE = 2'b01,
    LOW_POWER_MODE   = 2'b10,
    NORMAL_MODE      = 2'b11
  } power_mode_t;

  typedef enum logic [2:0] {
    ST_WAKE     = 3'b000,
    ST_IDLE     = 3'b001,
    ST_SHIFT    = 3'b010,
    ST_CONVERT  = 3'b011,
    ST_SHUTDOWN = 3'b100
  } seq_state_t;

endpackage : adc_ctrl_pkg

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
module pin_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// File: rtl/adc_control_byte_power_modes.sv
// Control-byte decoder and power-mode sequencer of a serial converter.
// How it works
// RULE1 - First one after chip select falls is the start bit, byte MSB.
// RULE2 - Bits 6 to 4 select which analog inputs are converted.
// RULE3 - Bit 3 one selects unipolar, zero selects bipolar conversion.
// RULE4 - Bit 2 one selects single-ended, zero pseudo-differential inputs.
// RULE5 - Bits 1 and 0: 00 full, 01 fast, 10 reduced, 11 normal.
// RULE6 - Converting is fully powered; between, sections follow the mode.
// RULE7 - After conversion enter the latest programmed mode until next byte.
// RULE8 - Reset, leaving full sleep or shutdown: full power, ready in 2us.
// RULE9 - Fast and reduced modes may convert again with no wake delay.
// RULE10 - A software sleep mode waits for the running conversion to end.
// RULE11 - A start bit during software sleep restores full power.
// RULE12 - Each new byte's power field sets the mode after its conversion.
// RULE13 - Shutdown low forces hardware sleep and aborts any conversion.
// RULE14 - Host waits about 1.2ms for an internal reference to settle.
// RULE15 - Host should spend that wait in fast or reduced mode.
// RULE16 - Conversion starts on the serial clock fall after the eighth bit.
// RULE17 - Bits are sampled on rising serial clock while chip select low.
// RULE18 - Strobe pulses one clock after the byte; floats with select high.
// RULE19 - Shutdown released returns to idle with nothing pending.
// RULE20 - The whole byte is latched at once after its eighth bit.
module adc_control_byte_power_modes
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned READY_WAIT = READY_CYCLES
) (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic       I_DIN,
  input  wire logic       I_HW_SHUTDOWN_N,
  output logic      [2:0] O_CHAN_SEL,
  output logic            O_POLARITY_SELECT,
  output logic            O_INPUT_CONFIG_SELECT,
  output logic      [1:0] O_POWER_FIELD,
  output logic            O_CONVERTING,
  output logic            O_COMPARATOR_ON,
  output logic            O_COMPARATOR_FULL,
  output logic            O_REFERENCE_ON,
  output logic            O_READY,
  output logic            O_CONV_STROBE,
  output logic            O_CONV_STROBE_OE
);

  typedef struct packed {
    seq_state_t  state;
    logic        sclk_d;
    logic [2:0]  bit_cnt;
    logic [6:0]  shift;
    logic        got_eight;
    logic [3:0]  fall_cnt;
    logic [7:0]  ctrl_word;
    power_mode_t mode;
    logic [15:0] wait_cnt;
    logic [2:0]  chan_sel;
    logic        polarity;
    logic        input_cfg;
    logic [1:0]  power_field;
    logic        converting;
    logic        comp_on;
    logic        comp_full;
    logic        ref_on;
    logic        ready;
    logic        strobe;
    logic        strobe_oe;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [3:0] pins_sync;
  logic       sclk_s;
  logic       cs_n_s;
  logic       din_s;
  logic       hw_shutdown_n_n_s;
  logic       rise;
  logic       fall;

  // Serial clock, select, data and shutdown all come from the host side.
  // Reset levels match the idle pins, so no false select or shutdown follows.
  pin_sync #(.WIDTH(4), .RST_VAL(4'h5)) u_sync (
    .clk (I_REF_CLK),
    .rst (I_RESET),
    .d   ({I_SCLK, I_CS_N, I_DIN, I_HW_SHUTDOWN_N}),
    .q   (pins_sync)
  );

  assign sclk_s   = pins_sync[3];
  assign cs_n_s   = pins_sync[2];
  assign din_s    = pins_sync[1];
  assign hw_shutdown_n_n_s = pins_sync[0];
  assign rise     = sclk_s & ~s_r.sclk_d & ~cs_n_s; // RULE17
  assign fall     = ~sclk_s & s_r.sclk_d & ~cs_n_s;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.sclk_d    = sclk_s;
    s_nxt.strobe    = 1'b0;
    s_nxt.strobe_oe = ~cs_n_s; // RULE18
    if (s_r.wait_cnt != 16'h0000) begin
      s_nxt.wait_cnt = s_r.wait_cnt - 16'h0001;
    end
    case (s_r.state)
      ST_WAKE: begin
        // Full power is applied at once; only the readiness waits. 
        if (s_r.wait_cnt == 16'h0000) begin
          s_nxt.ready = 1'b1; // RULE8
          s_nxt.state = ST_IDLE;
        end
      end
      ST_IDLE, ST_SHIFT: begin
        if (cs_n_s) begin
          s_nxt.state   = ST_IDLE;
          s_nxt.bit_cnt = 3'h0;
        end else if (s_r.got_eight && fall) begin
          s_nxt.got_eight  = 1'b0;
          s_nxt.state      = ST_CONVERT; // RULE16
          s_nxt.converting = 1'b1;
          s_nxt.fall_cnt   = 4'h0;
        end else if (rise && !s_r.got_eight) begin
          if (s_r.state == ST_IDLE) begin
            if (din_s) begin // RULE1
              s_nxt.state   = ST_SHIFT;
              s_nxt.bit_cnt = 3'h1;
              s_nxt.shift   = 7'h00;
              // Waking from any sleep restores full power for the
              // conversion; a full sleep also drops readiness.
              s_nxt.mode      = NORMAL_MODE; // RULE11
              s_nxt.comp_on   = 1'b1; // RULE6
              s_nxt.comp_full = 1'b1;
              s_nxt.ref_on    = 1'b1;
            end
          end else begin
            s_nxt.shift   = {s_r.shift[5:0], din_s};
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'(CTRL_BITS - 1)) begin
              s_nxt.ctrl_word   = {1'b1, s_r.shift[5:0], din_s}; // RULE20
              s_nxt.chan_sel    = s_r.shift[5:3]; // RULE2
              s_nxt.polarity    = s_r.shift[2]; // RULE3
              s_nxt.input_cfg   = s_r.shift[1]; // RULE4
              s_nxt.power_field = {s_r.shift[0], din_s}; // RULE5
              s_nxt.got_eight   = 1'b1;
              s_nxt.strobe      = 1'b1; // RULE18
            end
          end
        end
      end
      ST_CONVERT: begin
        if (fall) begin
          s_nxt.fall_cnt = s_r.fall_cnt + 4'h1;
        end
        if (fall && s_r.fall_cnt == 4'(CONV_SCLK_FALLS - 1)) begin
          // Software sleep takes effect only after the conversion ends.
          s_nxt.converting = 1'b0; // RULE10
          s_nxt.state      = ST_IDLE;
          s_nxt.bit_cnt    = 3'h0;
          s_nxt.mode       = power_mode_t'(s_r.power_field); // RULE7 RULE12
          case (power_mode_t'(s_r.power_field))
            FULL_SLEEP_MODE: begin
              s_nxt.comp_on = 1'b0; // RULE6
              s_nxt.comp_full = 1'b0;
              s_nxt.ref_on  = 1'b0;
              s_nxt.ready   = 1'b0;
            end
            QUICK_SLEEP_MODE, LOW_POWER_MODE: begin
              // Reference stays up, so the next start needs no wait.
              s_nxt.comp_full = 1'b0; // RULE9
            end
            default: begin
              s_nxt.comp_full = 1'b1;
            end
          endcase
        end
      end
      ST_SHUTDOWN: begin
        if (hw_shutdown_n_n_s) begin
          s_nxt.state    = ST_WAKE; // RULE19
          s_nxt.wait_cnt = 16'(READY_WAIT);
          s_nxt.comp_on  = 1'b1; // RULE8
          s_nxt.comp_full = 1'b1;
          s_nxt.ref_on   = 1'b1;
          s_nxt.mode     = NORMAL_MODE;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    // Leaving full sleep needs the same settle wait as a reset.
    if (s_r.state == ST_IDLE && s_r.mode == FULL_SLEEP_MODE &&
        s_nxt.mode == NORMAL_MODE) begin
      s_nxt.wait_cnt = 16'(READY_WAIT); // RULE8
    end
    if (s_r.wait_cnt == 16'h0001 && s_r.state != ST_SHUTDOWN) begin
      s_nxt.ready = 1'b1;
    end
    // Shutdown overrides everything, dropping the conversion unfinished.
    if (!hw_shutdown_n_n_s) begin
      s_nxt.state      = ST_SHUTDOWN; // RULE13
      s_nxt.converting = 1'b0;
      s_nxt.got_eight  = 1'b0;
      s_nxt.bit_cnt    = 3'h0;
      s_nxt.comp_on    = 1'b0;
      s_nxt.comp_full  = 1'b0;
      s_nxt.ref_on     = 1'b0;
      s_nxt.ready      = 1'b0;
      s_nxt.wait_cnt   = 16'h0000;
      s_nxt.strobe     = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      s_r             <= '0;
      s_r.state       <= ST_WAKE;
      s_r.sclk_d      <= 1'b0;
      s_r.ctrl_word   <= CTRL_WORD_RESET;
      s_r.mode        <= NORMAL_MODE;
      s_r.power_field <= 2'(NORMAL_MODE);
      s_r.wait_cnt    <= 16'(READY_WAIT);
      s_r.comp_on     <= 1'b1;
      s_r.comp_full   <= 1'b1;
      s_r.ref_on      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_CHAN_SEL            = s_r.chan_sel;
  assign O_POLARITY_SELECT     = s_r.polarity;
  assign O_INPUT_CONFIG_SELECT = s_r.input_cfg;
  assign O_POWER_FIELD         = s_r.power_field;
  assign O_CONVERTING          = s_r.converting;
  assign O_COMPARATOR_ON       = s_r.comp_on;
  assign O_COMPARATOR_FULL     = s_r.comp_full;
  assign O_REFERENCE_ON        = s_r.ref_on;
  assign O_READY               = s_r.ready;
  assign O_CONV_STROBE         = s_r.strobe;
  assign O_CONV_STROBE_OE      = s_r.strobe_oe;

endmodule : adc_control_byte_power_modes

// File: tb/adc_ctrl_checker.sv
// Port checker of the control-byte sequencer.
module adc_ctrl_checker #(
  parameter int unsigned READY_WAIT = 4
) (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_CS_N,
  input  wire logic       I_HW_SHUTDOWN_N,
  input  wire logic [2:0] O_CHAN_SEL,
  input  wire logic [1:0] O_POWER_FIELD,
  input  wire logic       O_CONVERTING,
  input  wire logic       O_COMPARATOR_ON,
  input  wire logic       O_COMPARATOR_FULL,
  input  wire logic       O_REFERENCE_ON,
  input  wire logic       O_READY,
  input  wire logic       O_CONV_STROBE,
  input  wire logic       O_CONV_STROBE_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RDY_MAX = READY_WAIT + 4;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // Aborted conversions are left out, since shutdown overrides the mode.
  sequence conv_end_s;
    $fell(O_CONVERTING) && I_HW_SHUTDOWN_N && $past(I_HW_SHUTDOWN_N, 4);
  endsequence
  sequence deselected_s;
    I_CS_N [*4];
  endsequence
  sequence selected_s;
    (!I_CS_N) [*4];
  endsequence
  chk_strobe_drive: assert property (
    selected_s |-> O_CONV_STROBE_OE) else $error("Strobe not driven.");
  chk_strobe_single: assert property (
    O_CONV_STROBE |=> !O_CONV_STROBE) else $error("Strobe too long.");
  chk_strobe_float: assert property (
    deselected_s |-> !O_CONV_STROBE_OE) else $error("Strobe driven.");
  chk_conv_power: assert property (
    O_CONVERTING |-> O_COMPARATOR_FULL && O_REFERENCE_ON)
    else $error("Conversion not fully powered.");
  chk_full_sleep: assert property (
    conv_end_s ##0 (O_POWER_FIELD == 2'b00) |->
    ##[0:2] (!O_COMPARATOR_ON && !O_REFERENCE_ON && !O_READY))
    else $error("Full sleep not entered.");
  chk_quick_sleep: assert property (
    conv_end_s ##0 (O_POWER_FIELD inside {2'b01, 2'b10}) |-> ##[0:2]
    (O_COMPARATOR_ON && !O_COMPARATOR_FULL && O_REFERENCE_ON && O_READY))
    else $error("Reduced mode wrong.");
  chk_shutdown_abort: assert property (
    $fell(I_HW_SHUTDOWN_N) |-> ##[1:4] !O_CONVERTING)
    else $error("Conversion not aborted.");
  chk_ready_wake: assert property (
    $fell(I_RESET) |-> (O_COMPARATOR_FULL && O_REFERENCE_ON)
    ##[1:RDY_MAX] O_READY) else $error("Ready late after reset.");
  chk_fields_latch: assert property (
    $changed({O_CHAN_SEL, O_POWER_FIELD}) |-> ##[0:1] O_CONV_STROBE)
    else $error("Fields changed without a byte.");
endmodule : adc_ctrl_checker

// File: tb/host_serial_master.sv
// Host serial master model sending control bytes in clock mode 0.
module host_serial_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  task automatic clk1(input logic d);
    o_din = d;
    #100 o_sclk = 1'b1;
    #100 o_sclk = 1'b0;
  endtask : clk1
  // The reference settle wait is scaled down to keep runs short.
  task automatic settle();
    #4000;
  endtask : settle
  task automatic xfer(input logic [7:0] b, input int unsigned zeros,
                      input int unsigned falls);
    o_cs_n = 1'b0;
    repeat (zeros) clk1(1'b0);
    for (int i = 7; i >= 0; i--) clk1(b[i]);
    repeat (falls) clk1(1'b0);
    #100 o_cs_n = 1'b1;
    // A deselected data line shows no stale value.
    o_din = ~o_din;
  endtask : xfer
endmodule : host_serial_master

// File: tb/testbench.sv
// Self-checking bench of the control-byte sequencer.
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RW = 4;
  logic       clk, rst, sclk, cs_n, din, hw_shutdown_n_n;
  logic [2:0] chan;
  logic [1:0] pf;
  logic       pol, cfg, conv, c_on, c_full, r_on, rdy, strb, strb_oe;
  logic [7:0] b;
  int         checks, miscompares, strobes, falls;
  host_serial_master host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  adc_control_byte_power_modes #(.READY_WAIT(RW)) DUT (
    .I_REF_CLK(clk), .I_RESET(rst), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_DIN(din), .I_HW_SHUTDOWN_N(hw_shutdown_n_n), .O_CHAN_SEL(chan),
    .O_POLARITY_SELECT(pol), .O_INPUT_CONFIG_SELECT(cfg),
    .O_POWER_FIELD(pf), .O_CONVERTING(conv), .O_COMPARATOR_ON(c_on),
    .O_COMPARATOR_FULL(c_full), .O_REFERENCE_ON(r_on), .O_READY(rdy),
    .O_CONV_STROBE(strb), .O_CONV_STROBE_OE(strb_oe));
  function automatic logic [3:0] pwr_exp(input logic [1:0] m);
    case (m)
      2'b00:   return 4'b0000;
      2'b11:   return 4'b1111;
      default: return 4'b1011;
    endcase
  endfunction : pwr_exp
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) if (strb === 1'b1) strobes++;
  always @(negedge sclk) if (conv === 1'b1) falls++;
  initial begin
    #300us;
    miscompares++;
    test_done();
  end
  initial begin
    rst    = 1'b1;
    hw_shutdown_n_n = 1'b1;
    void'($urandom(32'hea12));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("wake power", 4'b1110, {c_on, c_full, r_on, rdy})
    `CHK("reset field", 2'b11, pf)
    repeat (RW + 4) @(negedge clk);
    `CHK("ready", 1'b1, rdy)
    fork
      host.xfer(8'h8f, 0, 13);
      begin
        wait (conv === 1'b1);
        @(negedge clk);
        hw_shutdown_n_n = 1'b0;
        repeat (6) @(negedge clk);
        `CHK("abort", 1'b0, conv)
      end
    join
    hw_shutdown_n_n = 1'b1;
    repeat (RW + 12) @(negedge clk);
    `CHK("idle after shutdown", 2'b01, {conv, rdy})
    // After a shutdown the host waits for the reference in a quick sleep.
    host.xfer(8'h81, 0, 13);
    host.settle();
    `CHK("settle power", pwr_exp(2'b01), {c_on, c_full, r_on, rdy})
    // Modes cycle in order, so each sleep is left by the next start bit.
    for (int k = 0; k < 8; k++) begin
      b       = {1'b1, 5'($urandom), 2'(k)};
      falls   = 0;
      strobes = 0;
      host.xfer(b, $urandom_range(3), 13);
      repeat (8) @(negedge clk);
      `CHK("chan", b[6:4], chan)
      `CHK("polarity", b[3], pol)
      `CHK("config", b[2], cfg)
      `CHK("field", b[1:0], pf)
      `CHK("strobes", 1, strobes)
      `CHK("falls", 12, falls)
      `CHK("power", pwr_exp(b[1:0]), {c_on, c_full, r_on, rdy})
      `CHK("strobe float", 1'b0, strb_oe)
      repeat (RW + 4) @(negedge clk);
    end
    test_done();
  end
endmodule : testbench
bind adc_control_byte_power_modes adc_ctrl_checker #(.READY_WAIT(READY_WAIT))
  u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_CS_N(I_CS_N),
  .I_HW_SHUTDOWN_N(I_HW_SHUTDOWN_N), .O_CHAN_SEL(O_CHAN_SEL),
  .O_POWER_FIELD(O_POWER_FIELD), .O_CONVERTING(O_CONVERTING),
  .O_COMPARATOR_ON(O_COMPARATOR_ON), .O_COMPARATOR_FULL(O_COMPARATOR_FULL),
  .O_REFERENCE_ON(O_REFERENCE_ON), .O_READY(O_READY),
  .O_CONV_STROBE(O_CONV_STROBE), .O_CONV_STROBE_OE(O_CONV_STROBE_OE));
